// ==== logic/mcb_ctl_if.sv ====
`timescale 1ns/100ps
interface mcb_ctl_if;
    import mcb_pkg::*;
    logic                      record;
    logic                      rewind;
    logic                      fast;
    logic                      full_evt;
    logic [IDX_W:0]            index;
    logic [IDX_W-1:0]          rd_sel;
    logic [31:0]               rd_data;
    logic                      rel_tgt;
    logic                      rel_fnc;
    logic                      auto_sync;
    logic                      man_sync;
    logic                      active;
    logic [31:0]               new_pos;
    logic                      go;
    logic [31:0]               go_val;
    logic [31:0]               actual;
    logic [31:0]               target;
    logic [31:0]               func;
    modport ctl (output record, rewind, fast, rd_sel, rel_tgt, rel_fnc, auto_sync, man_sync,
                 active, new_pos, go, go_val,
                 input full_evt, index, rd_data, actual, target, func);
    modport smp (input record, rewind, fast, rd_sel, actual, output full_evt, index, rd_data);
    modport pos (input rel_tgt, rel_fnc, auto_sync, man_sync, active, new_pos, go, go_val,
                 output actual, target, func);
endinterface

// ==== logic/mcb_pkg.sv ====
// What this block does
// - Writing one to sample_record_bit starts or resumes sampling; it clears itself when full.
// - sample_rewind_bit zeroes the sample write index and sampling goes on from there.
// - fast_sample_bit gives one sample per 100 us, otherwise one per 1.3 ms.
// - On preset activation either relative bit gives a relative move, neither an absolute one.
// - target_relative_bit alone adds the preset to target_position.
// - function_relative_bit adds the preset to an internal move variable, target untouched.
// - actual_position wraps at plus or minus 2^31 without upsetting endless relative moves.
// - The same two relative bits steer moves made in analogue two-position mode.
// - auto_sync_bit on a passive to active change zeroes both errors and copies actual to function.
// - manual_sync_bit loads actual, target and scaled function position from new position.
// - The manual sync updates all three positions in one indivisible step.
package mcb_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] OFF_CTRL        = 12'h024;
    localparam logic [11:0] OFF_MODE        = 12'h100;
    localparam logic [11:0] OFF_NEW_POS     = 12'h104;
    localparam logic [11:0] OFF_STATUS      = 12'h108;
    localparam logic [11:0] OFF_ACTUAL      = 12'h10c;
    localparam logic [11:0] OFF_TARGET      = 12'h110;
    localparam logic [11:0] OFF_FUNCTION    = 12'h114;
    localparam logic [11:0] OFF_SAMPLE_SEL  = 12'h118;
    localparam logic [11:0] OFF_SAMPLE_DATA = 12'h11c;
    localparam logic [11:0] OFF_PRESET_BASE = 12'h140;
    // ----------------------------------------
    // Control bits
    // ----------------------------------------
    localparam int BIT_RECORD   = 0;
    localparam int BIT_REWIND   = 1;
    localparam int BIT_FAST     = 2;
    localparam int BIT_REL_TGT  = 3;
    localparam int BIT_REL_FNC  = 4;
    localparam int BIT_AUTOSYNC = 5;
    localparam int BIT_MANSYNC  = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_007f;
    // ----------------------------------------
    // Modes
    // ----------------------------------------
    localparam int MODE_W = 8;
    localparam logic [MODE_W-1:0] MODE_PASSIVE = 8'h00;
    localparam logic [MODE_W-1:0] MODE_BIPOS   = 8'h02;
    localparam logic [MODE_W-1:0] MODE_RESET   = 8'h00;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS      = 100;
    localparam int FAST_INTERVAL_NS   = 100_000;
    localparam int NORMAL_INTERVAL_NS = 1_300_000;
    localparam int FAST_CYCLES        = FAST_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int NORMAL_CYCLES      = NORMAL_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int TICK_W             = 16;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int SAMPLE_DEPTH = 512;
    localparam int IDX_W        = 9;
    localparam int PRESET_N     = 8;
    localparam int PSEL_W       = 3;
    localparam int FUNC_SHIFT   = 4;
    localparam int STEP_W       = 8;
endpackage

// ==== logic/mcb_pos.sv ====
`timescale 1ns/100ps
module mcb_pos (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic [mcb_pkg::STEP_W-1:0] enc_step,
    mcb_ctl_if.pos                          cif
);
    import mcb_pkg::*;
    logic [31:0] act_q, act_d, tgt_q, tgt_d, fnc_q, fnc_d, acc_q, acc_d;
    logic [31:0] ferr_q, ferr_d, fnerr_q, fnerr_d, gap;
    logic        act_was_q;

    assign gap = tgt_q - fnc_q;

    always_comb begin
        // Wraps freely; all comparisons use differences, never magnitudes
        act_d   = act_q + {{(32-STEP_W){enc_step[STEP_W-1]}}, enc_step};
        tgt_d   = tgt_q;
        fnc_d   = fnc_q;
        acc_d   = acc_q;
        if (acc_q != '0) begin
            fnc_d = acc_q[31] ? fnc_q - 1'b1 : fnc_q + 1'b1;
            acc_d = acc_q[31] ? acc_q + 1'b1 : acc_q - 1'b1;
        end else if (gap != '0) begin
            fnc_d = gap[31] ? fnc_q - 1'b1 : fnc_q + 1'b1;
        end
        if (cif.go) begin
            if (cif.rel_fnc) begin
                acc_d = acc_d + cif.go_val;
            end else if (cif.rel_tgt) begin
                tgt_d = tgt_q + cif.go_val;
            end else begin
                tgt_d = cif.go_val;
            end
        end
        ferr_d  = fnc_q - act_q;
        fnerr_d = tgt_q - fnc_q;
        if (cif.auto_sync && cif.active && !act_was_q) begin
            fnc_d   = act_q;
            tgt_d   = act_q;
            acc_d   = '0;
            ferr_d  = '0;
            fnerr_d = '0;
        end
        // Overrides the position and remainder updates in the same edge so no partial set is seen
        if (cif.man_sync) begin
            act_d   = cif.new_pos;
            tgt_d   = cif.new_pos;
            fnc_d   = (cif.new_pos + ferr_q) << FUNC_SHIFT;
            acc_d   = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act_q     <= '0;
            tgt_q     <= '0;
            fnc_q     <= '0;
            acc_q     <= '0;
            ferr_q    <= '0;
            fnerr_q   <= '0;
            act_was_q <= 1'b0;
        end else begin
            act_q     <= act_d;
            tgt_q     <= tgt_d;
            fnc_q     <= fnc_d;
            acc_q     <= acc_d;
            ferr_q    <= ferr_d;
            fnerr_q   <= fnerr_d;
            act_was_q <= cif.active;
        end
    end

    assign cif.actual = act_q;
    assign cif.target = tgt_q;
    assign cif.func   = fnc_q;
endmodule

// ==== logic/mcb_sampler.sv ====
`timescale 1ns/100ps
module mcb_sampler #(
    parameter int NORMAL_CYC = mcb_pkg::NORMAL_CYCLES
) (
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    mcb_ctl_if.smp     cif
);
    import mcb_pkg::*;
    logic [TICK_W-1:0] tick_q, tick_d, limit;
    logic [IDX_W:0]    idx_q, idx_d;
    logic              full_q, full_d, take;
    logic [31:0]       mem_q [SAMPLE_DEPTH];
    logic [31:0]       rd_q;

    assign limit = cif.fast ? TICK_W'(FAST_CYCLES - 1) : TICK_W'(NORMAL_CYC - 1);
    assign take  = cif.record && (tick_q >= limit) && (idx_q < (IDX_W+1)'(SAMPLE_DEPTH));

    always_comb begin
        tick_d = (tick_q >= limit) ? '0 : tick_q + 1'b1;
        idx_d  = idx_q;
        full_d = 1'b0;
        if (take) begin
            idx_d = idx_q + 1'b1;
        end
        if (cif.record && (idx_d == (IDX_W+1)'(SAMPLE_DEPTH))) begin
            full_d = 1'b1;
        end
        if (cif.rewind) begin
            idx_d  = '0;
            full_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tick_q <= '0;
            idx_q  <= '0;
            full_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            idx_q  <= idx_d;
            full_q <= full_d;
        end
    end

    // Buffer holds no reset; contents are only meaningful below the index
    always_ff @(posedge mclk) begin
        if (take && !cif.rewind) begin
            mem_q[idx_q[IDX_W-1:0]] <= cif.actual;
        end
        rd_q <= mem_q[cif.rd_sel];
    end

    assign cif.full_evt = full_q;
    assign cif.index    = idx_q;
    assign cif.rd_data  = rd_q;
endmodule

// ==== logic/mcb_top.sv ====
`timescale 1ns/100ps
module mcb_top #(
    parameter int NORMAL_CYC = mcb_pkg::NORMAL_CYCLES
) (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       fast_command,
    input  wire logic [mcb_pkg::PSEL_W-1:0] fast_preset,
    input  wire logic                       bipos_event,
    input  wire logic                       bipos_sel,
    input  wire logic [mcb_pkg::STEP_W-1:0] enc_step,
    output logic      [31:0]                actual_position,
    output logic      [31:0]                target_position,
    output logic      [31:0]                function_position
);
    import mcb_pkg::*;

    mcb_ctl_if cif ();

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [31:0]       ctrl_q, ctrl_d;
    logic [MODE_W-1:0] mode_q, mode_d;
    logic [31:0]       newp_q, newp_d;
    logic [31:0]       pre_q [PRESET_N];
    logic [31:0]       pre_d [PRESET_N];
    logic [IDX_W-1:0]  ssel_q, ssel_d;
    logic [31:0]       prdata_d;
    logic              pready_d, pslverr_d;
    logic              go_q, go_d;
    logic [31:0]       gval_q, gval_d;
    logic              wr, rd_hit, pre_hit;
    logic [PSEL_W-1:0] pre_idx;
    logic              bip_go;

    // Access phase answered one cycle after penable rises
    assign wr      = psel && penable && pready && pwrite;
    assign pre_hit = (paddr >= OFF_PRESET_BASE) &&
                     (paddr < OFF_PRESET_BASE + 12'(PRESET_N * 4)) && (paddr[1:0] == 2'b00);
    assign pre_idx = PSEL_W'((paddr - OFF_PRESET_BASE) >> 2);
    assign rd_hit  = pre_hit || (paddr == OFF_CTRL) || (paddr == OFF_MODE) ||
                     (paddr == OFF_NEW_POS) || (paddr == OFF_STATUS) ||
                     (paddr == OFF_ACTUAL) || (paddr == OFF_TARGET) ||
                     (paddr == OFF_FUNCTION) || (paddr == OFF_SAMPLE_SEL) ||
                     (paddr == OFF_SAMPLE_DATA);
    assign bip_go  = bipos_event && (mode_q == MODE_BIPOS);

    // ----------------------------------------
    // Control register and writes
    // ----------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        newp_d = newp_q;
        ssel_d = ssel_q;
        // Rewind and manual sync act once and drop
        ctrl_d[BIT_REWIND]  = 1'b0;
        ctrl_d[BIT_MANSYNC] = 1'b0;
        if (cif.full_evt) begin
            ctrl_d[BIT_RECORD] = 1'b0;
        end
        if (wr && (paddr == OFF_CTRL)) begin
            // A write of one wins over the self-clear in the same cycle
            ctrl_d = pwdata & CTRL_MASK;
        end
        if (wr && (paddr == OFF_MODE)) begin
            mode_d = pwdata[MODE_W-1:0];
        end
        if (wr && (paddr == OFF_NEW_POS)) begin
            newp_d = pwdata;
        end
        if (wr && (paddr == OFF_SAMPLE_SEL)) begin
            ssel_d = pwdata[IDX_W-1:0];
        end
    end

    for (genvar i = 0; i < PRESET_N; i++) begin : g_pre
        always_comb begin
            pre_d[i] = pre_q[i];
            if (wr && pre_hit && (pre_idx == PSEL_W'(i))) begin
                pre_d[i] = pwdata;
            end
        end
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                pre_q[i] <= '0;
            end else begin
                pre_q[i] <= pre_d[i];
            end
        end
    end

    // ----------------------------------------
    // Preset activation
    // ----------------------------------------
    always_comb begin
        go_d   = fast_command || bip_go;
        gval_d = gval_q;
        if (fast_command) begin
            gval_d = pre_q[fast_preset];
        end else if (bip_go) begin
            gval_d = bipos_sel ? pre_q[1] : pre_q[0];
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_comb begin
        pready_d  = psel && penable && !pready;
        pslverr_d = pready_d && !rd_hit;
        prdata_d  = '0;
        if (pready_d && !pwrite) begin
            unique case (1'b1)
                pre_hit:                     prdata_d = pre_q[pre_idx];
                paddr == OFF_CTRL:           prdata_d = ctrl_q;
                paddr == OFF_MODE:           prdata_d = {{(32-MODE_W){1'b0}}, mode_q};
                paddr == OFF_NEW_POS:        prdata_d = newp_q;
                paddr == OFF_STATUS:         prdata_d = {{(31-IDX_W){1'b0}}, cif.index};
                paddr == OFF_ACTUAL:         prdata_d = cif.actual;
                paddr == OFF_TARGET:         prdata_d = cif.target;
                paddr == OFF_FUNCTION:       prdata_d = cif.func;
                paddr == OFF_SAMPLE_SEL:     prdata_d = {{(32-IDX_W){1'b0}}, ssel_q};
                paddr == OFF_SAMPLE_DATA:    prdata_d = cif.rd_data;
                default:                     prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q            <= CTRL_RESET;
            mode_q            <= MODE_RESET;
            newp_q            <= '0;
            ssel_q            <= '0;
            go_q              <= 1'b0;
            gval_q            <= '0;
            prdata            <= '0;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            actual_position   <= '0;
            target_position   <= '0;
            function_position <= '0;
        end else begin
            ctrl_q            <= ctrl_d;
            mode_q            <= mode_d;
            newp_q            <= newp_d;
            ssel_q            <= ssel_d;
            go_q              <= go_d;
            gval_q            <= gval_d;
            prdata            <= prdata_d;
            pready            <= pready_d;
            pslverr           <= pslverr_d;
            actual_position   <= cif.actual;
            target_position   <= cif.target;
            function_position <= cif.func;
        end
    end

    // ----------------------------------------
    // Wiring to the engines
    // ----------------------------------------
    assign cif.record    = ctrl_q[BIT_RECORD];
    assign cif.rewind    = ctrl_q[BIT_REWIND];
    assign cif.fast      = ctrl_q[BIT_FAST];
    assign cif.rel_tgt   = ctrl_q[BIT_REL_TGT];
    assign cif.rel_fnc   = ctrl_q[BIT_REL_FNC];
    assign cif.auto_sync = ctrl_q[BIT_AUTOSYNC];
    assign cif.man_sync  = ctrl_q[BIT_MANSYNC];
    assign cif.active    = (mode_q != MODE_PASSIVE);
    assign cif.new_pos   = newp_q;
    assign cif.go        = go_q;
    assign cif.go_val    = gval_q;
    assign cif.rd_sel    = ssel_q;

    mcb_sampler #(
        .NORMAL_CYC (NORMAL_CYC)
    ) u_smp (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .cif     (cif)
    );

    mcb_pos u_pos (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .enc_step (enc_step),
        .cif      (cif)
    );
endmodule

// ==== verification/mcb_top_checker.sv ====
`timescale 1ns/100ps
module mcb_top_checker #(
    parameter int NORMAL_CYC = mcb_pkg::NORMAL_CYCLES
) (
    input wire logic                       mclk,
    input wire logic                       sys_rst,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       fast_command,
    input wire logic [mcb_pkg::PSEL_W-1:0] fast_preset,
    input wire logic                       bipos_event,
    input wire logic                       bipos_sel,
    input wire logic [mcb_pkg::STEP_W-1:0] enc_step,
    input wire logic [31:0]                actual_position,
    input wire logic [31:0]                target_position,
    input wire logic [31:0]                function_position
);
    import mcb_pkg::*;
    // ----------------------------------------
    // Shadow of software state
    // ----------------------------------------
    logic [31:0]       pre_q [PRESET_N];
    logic [31:0]       ctl_q;
    logic [31:0]       newp_q;
    logic [31:0]       exp_q;
    logic [MODE_W-1:0] mode_q;
    logic              wev;
    logic              trig;
    logic [PSEL_W-1:0] idx;

    assign wev  = psel && penable && pready && pwrite && !pslverr;
    assign trig = fast_command || (bipos_event && mode_q == MODE_BIPOS);
    assign idx  = fast_command ? fast_preset : PSEL_W'(bipos_sel);

    // Base taken from the output copy; moves are spaced apart by the bench
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctl_q  <= CTRL_RESET;
            mode_q <= MODE_RESET;
            newp_q <= '0;
            exp_q  <= '0;
            pre_q  <= '{default: '0};
        end else begin
            if (wev && paddr == OFF_CTRL) ctl_q <= pwdata;
            if (wev && paddr == OFF_MODE) mode_q <= pwdata[MODE_W-1:0];
            if (wev && paddr == OFF_NEW_POS) newp_q <= pwdata;
            if (wev && paddr[11:5] == OFF_PRESET_BASE[11:5]) pre_q[paddr[4:2]] <= pwdata;
            if (trig) exp_q <= ctl_q[BIT_REL_FNC] ? target_position :
                               ctl_q[BIT_REL_TGT] ? target_position + pre_q[idx] : pre_q[idx];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_ready_one_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("pready missing after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero outside answer");
    a_unaligned_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
    a_preset_move: assert property (trig |-> ##[1:4] target_position == exp_q)
        else $error("target after preset activation wrong");
    a_fnc_rel_hold: assert property (fast_command && ctl_q[BIT_REL_FNC] |=> $stable(target_position) [*3])
        else $error("target moved on function relative move");
    a_auto_sync: assert property (wev && paddr == OFF_MODE && mode_q == MODE_PASSIVE
        && pwdata[MODE_W-1:0] != MODE_PASSIVE && ctl_q[BIT_AUTOSYNC] && enc_step == '0
        |-> ##[1:4] (function_position == actual_position && target_position == actual_position))
        else $error("auto sync did not align positions");
    a_manual_sync: assert property (wev && paddr == OFF_CTRL && pwdata[BIT_MANSYNC]
        |-> ##[1:4] (actual_position == newp_q && target_position == newp_q))
        else $error("manual sync did not load positions together");
endmodule

bind mcb_top mcb_top_checker #(.NORMAL_CYC(NORMAL_CYC)) i_mcb_top_checker (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_command(fast_command), .fast_preset(fast_preset), .bipos_event(bipos_event),
    .bipos_sel(bipos_sel), .enc_step(enc_step), .actual_position(actual_position),
    .target_position(target_position), .function_position(function_position)
);

// ==== verification/mcb_top_tb.sv ====
`timescale 1ns/100ps
module mcb_top_tb;
    import mcb_pkg::*;
    // Short interval keeps a full buffer under 30k cycles
    localparam int NCYC = 50;
    logic              mclk = 1'b0;
    logic              sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic              fast_command, bipos_event, bipos_sel;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd, exp_tgt, exp_act, v;
    logic [31:0]       actual_position, target_position, function_position;
    logic [31:0]       pre [PRESET_N];
    logic [PSEL_W-1:0] fast_preset, s;
    logic [STEP_W-1:0] enc_step;
    int                num_errors = 0, total_checks = 0, cyc = 0, n, t0;

    always #50 mclk = ~mclk;

    mcb_top #(.NORMAL_CYC(NCYC)) i_mcb_top (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_command(fast_command), .fast_preset(fast_preset), .bipos_event(bipos_event),
        .bipos_sel(bipos_sel), .enc_step(enc_step), .actual_position(actual_position),
        .target_position(target_position), .function_position(function_position)
    );
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60_000) begin
            num_errors++;
            wrap_up;
        end
    end

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        // Idle edge between calls, so psel is never driven twice in one step
        if (psel) @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        check(nm, e, rd);
    endtask

    function automatic logic [31:0] fn_move(input logic [1:0] m, input logic [31:0] t,
                                            input logic [31:0] p);
        return m[1] ? t : (m[0] ? t + p : p);
    endfunction

    task automatic step(input logic [STEP_W-1:0] d, input int k);
        enc_step <= d;
        repeat (k) @(posedge mclk);
        enc_step <= '0;
        exp_act = exp_act + 32'($signed(d)) * 32'(k);
        repeat (3) @(posedge mclk);
    endtask

    // One activation per relative-bit setting, by command or two-position event
    task automatic move_round(input logic b);
        for (int m = 0; m < 4; m++) begin
            s = 3'($urandom_range(PRESET_N - 1));
            apb(1'b1, OFF_CTRL, 32'h0000_0020 | (32'(m) << 3));
            fast_command <= b;
            bipos_event <= !b;
            fast_preset <= s;
            bipos_sel <= s[0];
            @(posedge mclk);
            fast_command <= 1'b0;
            bipos_event <= 1'b0;
            repeat (5) @(posedge mclk);
            exp_tgt = fn_move(2'(m), exp_tgt, pre[b ? s : PSEL_W'(s[0])]);
            check("target", exp_tgt, target_position);
        end
        $display("move round done");
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {sys_rst, psel, penable, pwrite, fast_command, bipos_event, bipos_sel} = 7'b100_0000;
        paddr = '0;
        pwdata = '0;
        fast_preset = '0;
        enc_step = '0;
        exp_tgt = '0;
        exp_act = '0;
        void'($urandom(32'hece7));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk("ctrl reset", OFF_CTRL, CTRL_RESET);
        apb(1'b0, 12'h200, '0);
        check("unmapped", 32'h1, 32'(err));
        apb(1'b1, 12'h026, '1);
        check("unaligned", 32'h1, 32'(err));
        v = $urandom & 32'hffff_ff38;
        apb(1'b1, OFF_CTRL, v);
        rchk("ctrl rw", OFF_CTRL, v & CTRL_MASK);
        $display("register test done");
        for (int i = 0; i < PRESET_N; i++) begin
            pre[i] = $urandom_range(255);
            apb(1'b1, OFF_PRESET_BASE + 12'(4 * i), pre[i]);
        end
        move_round(1'b1);
        // Small presets so relative remainders drain before the syncs
        repeat (600) @(posedge mclk);
        apb(1'b1, OFF_NEW_POS, 32'h7fff_fff0);
        apb(1'b1, OFF_CTRL, 32'h0000_0060);
        repeat (3) @(posedge mclk);
        exp_act = 32'h7fff_fff0;
        exp_tgt = exp_act;
        check("sync actual", exp_act, actual_position);
        check("sync target", exp_tgt, target_position);
        rchk("sync clear", OFF_CTRL, 32'h0000_0020);
        step(8'h08, 4);
        check("wrap", 32'h8000_0010, actual_position);
        $display("sync test done");
        step(8'($urandom), $urandom_range(40, 5));
        apb(1'b1, OFF_MODE, 32'(MODE_BIPOS));
        repeat (3) @(posedge mclk);
        exp_tgt = exp_act;
        check("auto target", exp_act, target_position);
        check("auto function", exp_act, function_position);
        $display("auto sync test done");
        move_round(1'b0);
        apb(1'b1, OFF_MODE, '0);
        apb(1'b1, OFF_CTRL, 32'h0000_0023);
        t0 = cyc;
        n = 0;
        do begin
            repeat (NCYC) @(posedge mclk);
            apb(1'b0, OFF_CTRL, '0);
            n++;
        end while (rd[0] && n < 600);
        check("fill time", 32'h1, 32'(cyc - t0 >= 511 * NCYC));
        apb(1'b0, OFF_STATUS, '0);
        check("full index", 32'd512, 32'(rd[9:0]));
        apb(1'b1, OFF_CTRL, 32'h0000_0027);
        repeat (2500) @(posedge mclk);
        apb(1'b0, OFF_STATUS, '0);
        check("fast index", 32'h1, 32'(rd[9:0] inside {[2:3]}));
        apb(1'b1, OFF_CTRL, 32'h0000_0027);
        apb(1'b0, OFF_STATUS, '0);
        check("rewind index", 32'h0, 32'(rd[9:0]));
        rchk("rewind clear", OFF_CTRL, 32'h0000_0025);
        repeat (1100) @(posedge mclk);
        apb(1'b0, OFF_STATUS, '0);
        check("resume index", 32'h1, 32'(rd[9:0] inside {[1:2]}));
        // Position is still since auto sync, so entry 0 holds it
        apb(1'b1, OFF_SAMPLE_SEL, '0);
        rchk("sample data", OFF_SAMPLE_DATA, exp_act);
        rchk("actual reg", OFF_ACTUAL, exp_act);
        rchk("preset reg", OFF_PRESET_BASE + 12'h004, pre[1]);
        $display("sampler test done");
        wrap_up;
    end
endmodule
